/* File: core/host_port_defs.svh */
// constants for the host port select and interrupt block
`ifndef HOST_PORT_DEFS_SVH
`define HOST_PORT_DEFS_SVH

// strap level that selects the two-wire bus (pull-up default)
`define HP_STRAP_TWO_WIRE   1'h1
// active level of the four-wire chip select
`define HP_CS_ACTIVE        1'h0
// open-drain drive level and output-enable levels (enable is active low)
`define HP_OD_LOW           1'h0
`define HP_OE_DRIVE         1'h0
`define HP_OE_RELEASE       1'h1

// widths
`define HP_ADDR_W           2
`define HP_SRC_W            5

// interrupt source bit positions
`define HP_SRC_PIN_CHANGE   0
`define HP_SRC_RX_ERROR     1
`define HP_SRC_RX_DATA      2
`define HP_SRC_TX_SPACE     3
`define HP_SRC_MODEM        4

// reset values
`define HP_ADDR_RST         2'h0
`define HP_BIT_RST          1'h0

`endif

/* File: core/host_port_pkg.sv */
// types for the host port select and interrupt block
`include "host_port_defs.svh"

package host_port_pkg;

  // host interface mode chosen by the strap
  typedef enum logic {
    MODE_FOUR_WIRE = 1'b0,
    MODE_TWO_WIRE  = 1'b1
  } mode_t;

  // strap capture sequence, gray coded
  typedef enum logic [1:0] {
    ST_HOLD   = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_RUN    = 2'b11
  } phase_t;

  // whole state of the pin mux
  typedef struct packed {
    phase_t                 phase;
    mode_t                  mode;
    logic                   cs_active;
    logic                   serial_in;
    logic                   serial_clk;
    logic [`HP_ADDR_W-1:0]  slave_addr;
    logic                   so_out;
    logic                   so_oe_n;
    logic                   sda_out;
    logic                   sda_oe_n;
    logic                   sda_in;
  } mux_state_t;

  // whole state of the interrupt driver
  typedef struct packed {
    logic                   irq_out;
    logic                   irq_oe_n;
  } irq_state_t;

endpackage

/* File: core/irq_open_drain.sv */
// open-drain active-low interrupt driver gated by the enable register
`timescale 1ns/1ps
`include "host_port_defs.svh"

module irq_open_drain (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic [`HP_SRC_W-1:0]  interrupt_enable_reg,
  input  wire logic [`HP_SRC_W-1:0]  irq_pending,
  output logic                       irq_out,
  output logic                       irq_oe_n
);

  host_port_pkg::irq_state_t st_r;
  host_port_pkg::irq_state_t st_nxt;
  logic                      any_enabled;

  // only enabled sources count, pull low while any remains
  always_comb begin
    st_nxt          = st_r;
    any_enabled     = |(interrupt_enable_reg & irq_pending);
    st_nxt.irq_out  = `HP_OD_LOW;
    st_nxt.irq_oe_n = any_enabled ? `HP_OE_DRIVE : `HP_OE_RELEASE;
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r.irq_out  <= `HP_OD_LOW;
      st_r.irq_oe_n <= `HP_OE_RELEASE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign irq_out  = st_r.irq_out;
  assign irq_oe_n = st_r.irq_oe_n;

  // pin pulled low whenever an enabled source was pending
  chk_irq_drive_low: assert property (@(posedge core_clk) disable iff (rst)
    (|(interrupt_enable_reg & irq_pending)) |=> (irq_oe_n == `HP_OE_DRIVE))
    else $error("interrupt not driven for enabled pending source");

  // disabled sources alone never drive the pin
  chk_irq_masked: assert property (@(posedge core_clk) disable iff (rst)
    ((interrupt_enable_reg & irq_pending) == '0) |=> (irq_oe_n == `HP_OE_RELEASE))
    else $error("interrupt driven with no enabled source");

  // released within one cycle of the last enabled source going away
  chk_irq_release: assert property (@(posedge core_clk) disable iff (rst)
    $fell(|(interrupt_enable_reg & irq_pending)) && !$past(rst) |=> $rose(irq_oe_n))
    else $error("interrupt not released after sources cleared");

  // the modem status source bit alone can raise the interrupt
  chk_irq_sources: assert property (@(posedge core_clk) disable iff (rst)
    (interrupt_enable_reg[`HP_SRC_MODEM] && irq_pending[`HP_SRC_MODEM])
      |=> !irq_oe_n && !irq_out)
    else $error("modem status source ignored");

endmodule

/* File: core/host_port_select_and_irq.sv */
// host interface strap select, shared pin roles and interrupt output
// Notes on behaviour
// - strap high two-wire bus, low four-wire serial
// - unconnected strap defaults to two-wire bus
// - four-wire: pin zero is active-low chip select
// - two-wire: both shared pins set slave address
// - four-wire: pin one is serial data input
// - serial output driven only while selected
// - two-wire data pin open-drain; four-wire unused
// - interrupt pin open-drain, low when pending
// - only enabled sources may drive interrupt
// - five interrupt source kinds feed the pin
`timescale 1ns/1ps
`include "host_port_defs.svh"

module host_port_select_and_irq (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  iface_sel_strap,
  input  wire logic                  select_or_addr_bit0,
  input  wire logic                  serial_in_or_addr_bit1,
  input  wire logic                  host_clk_pin,
  input  wire logic                  so_data,
  input  wire logic                  sda_pin_in,
  input  wire logic                  sda_pull_low,
  input  wire logic [`HP_SRC_W-1:0]  interrupt_enable_reg,
  input  wire logic [`HP_SRC_W-1:0]  irq_pending,
  output logic                       mode_two_wire,
  output logic                       run_ready,
  output logic                       cs_active,
  output logic                       serial_in,
  output logic                       serial_clk,
  output logic [`HP_ADDR_W-1:0]      slave_addr,
  output logic                       sda_in,
  output logic                       so_out,
  output logic                       so_oe_n,
  output logic                       sda_out,
  output logic                       sda_oe_n,
  output logic                       irq_out,
  output logic                       irq_oe_n
);

  host_port_pkg::mux_state_t st_r;
  host_port_pkg::mux_state_t st_nxt;
  logic                      four_wire_live;
  logic                      two_wire_live;

  // four-wire chip select decode, shared by select flag and output enable
  function automatic logic chip_selected(input logic live,
                                         input logic cs_pin);
    return live && (cs_pin == `HP_CS_ACTIVE);
  endfunction

  // phase sequence, strap capture and pin roles
  always_comb begin
    st_nxt         = st_r;
    four_wire_live = (st_r.phase == host_port_pkg::ST_RUN) &&
                     (st_r.mode == host_port_pkg::MODE_FOUR_WIRE);
    two_wire_live  = (st_r.phase == host_port_pkg::ST_RUN) &&
                     (st_r.mode == host_port_pkg::MODE_TWO_WIRE);
    case (st_r.phase)
      host_port_pkg::ST_HOLD: begin
        st_nxt.phase = host_port_pkg::ST_SAMPLE;
      end
      host_port_pkg::ST_SAMPLE: begin
        // latch once, never again until reset
        st_nxt.mode  = (iface_sel_strap == `HP_STRAP_TWO_WIRE) ?
                       host_port_pkg::MODE_TWO_WIRE : host_port_pkg::MODE_FOUR_WIRE;
        st_nxt.phase = host_port_pkg::ST_RUN;
      end
      host_port_pkg::ST_RUN: begin
        st_nxt.phase = host_port_pkg::ST_RUN;
      end
      default: begin
        st_nxt.phase = host_port_pkg::ST_HOLD;
      end
    endcase
    // four-wire roles, and the clock pin forwarded in both modes
    st_nxt.cs_active  = chip_selected(four_wire_live, select_or_addr_bit0);
    st_nxt.serial_in  = four_wire_live ? serial_in_or_addr_bit1 : `HP_BIT_RST;
    st_nxt.serial_clk = (st_r.phase == host_port_pkg::ST_RUN) ? host_clk_pin : `HP_BIT_RST;
    st_nxt.so_out     = four_wire_live ? so_data : `HP_BIT_RST;
    st_nxt.so_oe_n    = chip_selected(four_wire_live, select_or_addr_bit0) ?
                        `HP_OE_DRIVE : `HP_OE_RELEASE;
    // two-wire roles
    st_nxt.slave_addr = two_wire_live ? {serial_in_or_addr_bit1, select_or_addr_bit0} :
                        `HP_ADDR_RST;
    st_nxt.sda_out    = `HP_OD_LOW;
    st_nxt.sda_oe_n   = (two_wire_live && sda_pull_low) ? `HP_OE_DRIVE : `HP_OE_RELEASE;
    st_nxt.sda_in     = two_wire_live ? sda_pin_in : `HP_BIT_RST;
  end

  // state register; mode resets to two-wire as an open strap would give
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r.phase      <= host_port_pkg::ST_HOLD;
      st_r.mode       <= host_port_pkg::MODE_TWO_WIRE;
      st_r.cs_active  <= `HP_BIT_RST;
      st_r.serial_in  <= `HP_BIT_RST;
      st_r.serial_clk <= `HP_BIT_RST;
      st_r.slave_addr <= `HP_ADDR_RST;
      st_r.so_out     <= `HP_BIT_RST;
      st_r.so_oe_n    <= `HP_OE_RELEASE;
      st_r.sda_out    <= `HP_OD_LOW;
      st_r.sda_oe_n   <= `HP_OE_RELEASE;
      st_r.sda_in     <= `HP_BIT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state flops
  assign mode_two_wire = (st_r.mode == host_port_pkg::MODE_TWO_WIRE);
  assign run_ready     = st_r.phase[1];  // run is the only reachable state with bit 1 set
  assign cs_active     = st_r.cs_active;
  assign serial_in     = st_r.serial_in;
  assign serial_clk    = st_r.serial_clk;
  assign slave_addr    = st_r.slave_addr;
  assign sda_in        = st_r.sda_in;
  assign so_out        = st_r.so_out;
  assign so_oe_n       = st_r.so_oe_n;
  assign sda_out       = st_r.sda_out;
  assign sda_oe_n      = st_r.sda_oe_n;

  // interrupt pin driver
  irq_open_drain u_irq (
    .core_clk             (core_clk),
    .rst                  (rst),
    .interrupt_enable_reg (interrupt_enable_reg),
    .irq_pending          (irq_pending),
    .irq_out              (irq_out),
    .irq_oe_n             (irq_oe_n)
  );

  // strap seen in the sample phase decides the mode
  chk_mode_from_strap: assert property (@(posedge core_clk) disable iff (rst)
    (st_r.phase == host_port_pkg::ST_SAMPLE) |=> (mode_two_wire == $past(iface_sel_strap)))
    else $error("mode does not follow strap");

  // mode is two-wire through reset and the cycle after
  chk_mode_default: assert property (@(posedge core_clk)
    $past(rst) |-> mode_two_wire && !run_ready)
    else $error("mode not two-wire after reset");

  // mode frozen once running
  chk_mode_held: assert property (@(posedge core_clk) disable iff (rst)
    run_ready && $past(run_ready) |-> $stable(mode_two_wire))
    else $error("mode changed during operation");

  // chip select follows low pin level only in four-wire mode
  chk_cs_select: assert property (@(posedge core_clk) disable iff (rst)
    run_ready && !mode_two_wire && (select_or_addr_bit0 == `HP_CS_ACTIVE) ##1 run_ready
      |-> cs_active)
    else $error("chip select not taken from shared pin");

  // address follows both pins in two-wire mode
  chk_addr_pins: assert property (@(posedge core_clk) disable iff (rst)
    run_ready && mode_two_wire |=>
      slave_addr == {$past(serial_in_or_addr_bit1), $past(select_or_addr_bit0)})
    else $error("slave address not from shared pins");

  // serial data input passed in four-wire mode
  chk_serial_in: assert property (@(posedge core_clk) disable iff (rst)
    run_ready && !mode_two_wire |=> serial_in == $past(serial_in_or_addr_bit1))
    else $error("serial data input not forwarded");

  // serial output drives only while selected in four-wire mode
  chk_so_tristate: assert property (@(posedge core_clk) disable iff (rst)
    (so_oe_n == `HP_OE_DRIVE) |-> !mode_two_wire && cs_active)
    else $error("serial output driven while not selected");

  // data pin never driven outside two-wire mode
  chk_sda_mode: assert property (@(posedge core_clk) disable iff (rst)
    (sda_oe_n == `HP_OE_DRIVE) |-> mode_two_wire && (sda_out == `HP_OD_LOW))
    else $error("data pin driven in four-wire mode");

  // hold always moves on to the strap sample phase
  chk_phase_order: assert property (@(posedge core_clk) disable iff (rst)
    (st_r.phase == host_port_pkg::ST_HOLD) |=> (st_r.phase == host_port_pkg::ST_SAMPLE))
    else $error("strap capture skipped its sample phase");

  // no chip select seen while in two-wire mode
  chk_cs_two_wire: assert property (@(posedge core_clk) disable iff (rst)
    mode_two_wire |-> !cs_active)
    else $error("chip select active in two-wire mode");

  // high select pin ends the frame on the next edge
  chk_cs_release: assert property (@(posedge core_clk) disable iff (rst)
    run_ready && (select_or_addr_bit0 != `HP_CS_ACTIVE) |=> !cs_active)
    else $error("chip select held after pin went high");

  // selected four-wire port drives its serial output
  chk_so_drive: assert property (@(posedge core_clk) disable iff (rst)
    run_ready && !mode_two_wire && (select_or_addr_bit0 == `HP_CS_ACTIVE)
      |=> (so_oe_n == `HP_OE_DRIVE))
    else $error("serial output not driven while selected");

  // driven serial output carries the core data
  chk_so_data: assert property (@(posedge core_clk) disable iff (rst)
    (so_oe_n == `HP_OE_DRIVE) |-> (so_out == $past(so_data)))
    else $error("serial output does not carry core data");

  // two-wire shared pins never feed the serial input
  chk_si_two_wire: assert property (@(posedge core_clk) disable iff (rst)
    mode_two_wire |-> !serial_in)
    else $error("serial input active in two-wire mode");

  // four-wire mode leaves the slave address at its reset value
  chk_addr_four_wire: assert property (@(posedge core_clk) disable iff (rst)
    !mode_two_wire |-> (slave_addr == `HP_ADDR_RST))
    else $error("slave address set in four-wire mode");

  // core pull request reaches the data pin in two-wire mode
  chk_sda_pull: assert property (@(posedge core_clk) disable iff (rst)
    run_ready && mode_two_wire && sda_pull_low |=> (sda_oe_n == `HP_OE_DRIVE))
    else $error("data pin not pulled low on request");

  // data pin level passed to the core in two-wire mode
  chk_sda_in: assert property (@(posedge core_clk) disable iff (rst)
    run_ready && mode_two_wire |=> (sda_in == $past(sda_pin_in)))
    else $error("data pin level not forwarded");

  // shared clock pin forwarded once running
  chk_clk_follow: assert property (@(posedge core_clk) disable iff (rst)
    run_ready |=> (serial_clk == $past(host_clk_pin)))
    else $error("clock pin level not forwarded");

endmodule

/* File: tb/host_model.sv */
// board and host side of the shared pins: pull-ups and wire resolution
`timescale 1ns/1ps

module host_model (
  input  wire logic strap_float,
  input  wire logic strap_lvl,
  input  wire logic mode_two_wire,
  input  wire logic host_sda_rel,
  input  wire logic sda_out,
  input  wire logic sda_oe_n,
  input  wire logic irq_out,
  input  wire logic irq_oe_n,
  output logic      strap_pin,
  output logic      sda_wire,
  output logic      irq_wire
);
  // an open strap pin floats high through the internal pull-up
  assign strap_pin = strap_float ? 1'h1 : strap_lvl;
  // data line: tied to ground in four-wire, wired-and with pull-up in two-wire
  assign sda_wire = !mode_two_wire ? 1'b0
                  : ((sda_oe_n ? 1'h1 : sda_out) & host_sda_rel);
  // interrupt line idles high through the external resistor
  assign irq_wire = irq_oe_n ? 1'h1 : irq_out;
endmodule

/* File: tb/tb_top.sv */
// table-driven bench for the host port select and interrupt block
`timescale 1ns/1ps
`include "host_port_defs.svh"

module tb_top;
  logic                 core_clk, rst, strap_float, strap_lvl, b0, b1, sck, sod, pull;
  logic                 host_sda_rel, strap_pin, sda_wire, irq_wire;
  logic [`HP_SRC_W-1:0] en, pend;
  logic                 mode_two_wire, run_ready, cs_active, serial_in, serial_clk;
  logic [`HP_ADDR_W-1:0] slave_addr;
  logic                 sda_in, so_out, so_oe_n, sda_out, sda_oe_n, irq_out, irq_oe_n;
  int                   num_errors, comparisons;
  // inputs {strap,b1,b0,sck,sod,pull,en,pend}, then expected
  // {mode,cs,si,sclk,addr,so_oe_n,so_out,sda_oe_n,sda_in,irq}
  logic [26:0]          rows [5];

  host_model u_host_model (.strap_float(strap_float), .strap_lvl(strap_lvl),
    .mode_two_wire(mode_two_wire), .host_sda_rel(host_sda_rel), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .irq_out(irq_out), .irq_oe_n(irq_oe_n),
    .strap_pin(strap_pin), .sda_wire(sda_wire), .irq_wire(irq_wire));

  host_port_select_and_irq u_host_port_select_and_irq (.core_clk(core_clk), .rst(rst),
    .iface_sel_strap(strap_pin), .select_or_addr_bit0(b0), .serial_in_or_addr_bit1(b1),
    .host_clk_pin(sck), .so_data(sod), .sda_pin_in(sda_wire), .sda_pull_low(pull),
    .interrupt_enable_reg(en), .irq_pending(pend), .mode_two_wire(mode_two_wire),
    .run_ready(run_ready), .cs_active(cs_active), .serial_in(serial_in),
    .serial_clk(serial_clk), .slave_addr(slave_addr), .sda_in(sda_in), .so_out(so_out),
    .so_oe_n(so_oe_n), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq_out(irq_out),
    .irq_oe_n(irq_oe_n));

  // clock generation
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // compare one value against its expectation
  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // print counts and verdict, end the run
  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // reset for five cycles, check quiet outputs, then run past pin-live edge
  task automatic do_reset();
    rst = 1'b1;
    repeat (5) @(negedge core_clk);
    chk({7'h00, run_ready, so_oe_n, sda_oe_n, irq_oe_n}, 11'h007);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    chk({10'h000, run_ready}, 11'h001);
  endtask

  // main sequence
  initial begin
    rst = 1'b1; strap_float = 1'b0; strap_lvl = 1'b1; b0 = 1'b1; b1 = 1'b0;
    sck = 1'b0; sod = 1'b0; pull = 1'b0; host_sda_rel = 1'b1;
    en = 5'h00; pend = 5'h00;
    num_errors = 0; comparisons = 0;
    rows[0] = 27'b0_1_0_1_1_1_00100_00100_0_1_1_1_00_0_1_1_0_0;
    rows[1] = 27'b0_0_1_0_1_0_11111_00000_0_0_0_0_00_1_1_1_0_1;
    rows[2] = 27'b1_1_0_1_1_1_01011_10100_1_0_0_1_10_1_0_0_0_1;
    rows[3] = 27'b1_0_1_0_0_0_10000_10000_1_0_0_0_01_1_0_1_1_0;
    rows[4] = 27'b1_1_1_0_0_1_00001_00011_1_0_0_0_11_1_0_0_0_0;
    @(negedge core_clk);
    // table of ordinary cases, each after its own reset
    for (int i = 0; i < 5; i++) begin
      {strap_lvl, b1, b0, sck, sod, pull, en, pend} = rows[i][26:11];
      do_reset();
      chk({mode_two_wire, cs_active, serial_in, serial_clk, slave_addr, so_oe_n, so_out, sda_oe_n,
           sda_in, irq_wire}, rows[i][10:0]);
      $display("row %0d done", i);
    end
    // strap moved after capture is ignored
    strap_lvl = 1'b0;
    repeat (3) @(negedge core_clk);
    chk({8'h00, mode_two_wire, slave_addr}, 11'h007);
    // host holds data line low while device releases it
    pull = 1'b0; host_sda_rel = 1'b0;
    repeat (3) @(negedge core_clk);
    chk({9'h000, sda_oe_n, sda_in}, 11'h002);
    host_sda_rel = 1'b1;
    $display("strap hold and data line done");
    // every source alone: enabled drives, disabled never drives
    for (int s = 0; s < `HP_SRC_W; s++) begin
      en = 5'h01 << s; pend = 5'h01 << s;
      @(negedge core_clk);
      chk({10'h000, irq_wire}, 11'h000);
      pend = ~en;
      @(negedge core_clk);
      chk({10'h000, irq_wire}, 11'h001);
    end
    $display("interrupt sources done");
    // open strap pin defaults to two-wire
    strap_float = 1'b1;
    do_reset();
    chk({10'h000, mode_two_wire}, 11'h001);
    $display("open strap done");
    // four-wire chip select then release
    strap_float = 1'b0; strap_lvl = 1'b0; b0 = 1'b1; sod = 1'b1;
    do_reset();
    b0 = 1'b0;
    @(negedge core_clk);
    chk({8'h00, cs_active, so_oe_n, so_out}, 11'h005);
    b0 = 1'b1;
    @(negedge core_clk);
    chk({9'h000, cs_active, so_oe_n}, 11'h001);
    $display("chip select done");
    summarize();
  end

  // watchdog against a hang
  initial begin
    repeat (3000) @(posedge core_clk);
    num_errors++;
    summarize();
  end
endmodule
